// >>> hw/dac_trigger_control.sv
// Two-channel converter control: register port, mode register, sample
// registers, a sample queue for channel 0 and two channel slices.
// Assumes timer match events are one-cycle pulses on this clock and that
// the analog stage outside turns each code and enable into a pin level.
`timescale 1ns/1ps
`include "dac_trigger_regs.svh"

module dac_trigger_control (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire dac_trigger_pkg::bus_req_s bus_i,
    output dac_trigger_pkg::code_t rdata_o,
    input wire logic timer1_match_event_i,
    input wire logic timer2_match_event_i,
    output dac_trigger_pkg::code_t analog_out_ch0_o,
    output logic analog_out_ch0_oe_o,
    output dac_trigger_pkg::code_t analog_out_ch1_o,
    output logic analog_out_ch1_oe_o,
    output logic sample_queue_ready_o
);
    import dac_trigger_pkg::*;

    top_state_s st_reg;
    top_state_s st_next;

    chan_ctrl_s ctrl [2];
    logic trig [2];
    logic load [2];
    code_t load_val [2];
    code_t held [2];
    code_t code [2];
    logic oe [2];

    logic wr_sample0;
    logic wr_sample1;
    logic wr_mode;
    logic wr_queue;
    logic wr_status;
    logic q_in_ready;
    logic q_out_valid;
    logic q_pop;
    code_t q_data;

    // Address decode shared by all write strobes; the read path decodes the address in its own case
    function automatic logic hit(input bus_req_s b, input addr_t ofs);
        hit = (b.addr == ofs);
    endfunction : hit

    // Write strobes, one per writable register
    assign wr_sample0 = bus_i.wr && hit(bus_i, `OFS_SAMPLE0);
    assign wr_sample1 = bus_i.wr && hit(bus_i, `OFS_SAMPLE1);
    assign wr_mode = bus_i.wr && hit(bus_i, `OFS_MODE);
    assign wr_queue = bus_i.wr && hit(bus_i, `OFS_QUEUE);
    assign wr_status = bus_i.wr && hit(bus_i, `OFS_STATUS);

    // Queue drains into sample 0 continuously in normal mode, but only on
    // a timer 1 event in real-time mode; there it backs up and fills.
    // A direct write to sample 0 wins the cycle so neither value is lost.
    assign q_pop = q_out_valid && !wr_sample0 &&
        (!st_reg.mode[`MODE_RT0_BIT] || timer1_match_event_i);

    dac_sample_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`QUEUE_DEPTH)
    ) u_queue (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(wr_queue),
        .in_ready_o(q_in_ready),
        .in_data_i(bus_i.wdata),
        .out_valid_o(q_out_valid),
        .out_ready_i(q_pop),
        .out_data_o(q_data)
    );

    // Channel control from the mode register
    always_comb begin
        ctrl[0].en = st_reg.mode[`MODE_EN0_BIT];
        ctrl[0].rt = st_reg.mode[`MODE_RT0_BIT];
        ctrl[1].en = st_reg.mode[`MODE_EN1_BIT];
        ctrl[1].rt = st_reg.mode[`MODE_RT1_BIT];
    end

    // Each channel has its own trigger timer and sample register
    always_comb begin
        trig[0] = timer1_match_event_i;
        trig[1] = timer2_match_event_i;
        held[0] = st_reg.sample0;
        held[1] = st_reg.sample1;
        load[0] = wr_sample0 || q_pop;
        load[1] = wr_sample1;
        load_val[0] = wr_sample0 ? bus_i.wdata : q_data;
        load_val[1] = bus_i.wdata;
    end

    // Two identical channel slices
    for (genvar i = 0; i < 2; i++) begin : g_chan
        dac_channel u_chan (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .ctrl_i(ctrl[i]),
            .trigger_i(trig[i]),
            .load_i(load[i]),
            .load_value_i(load_val[i]),
            .held_value_i(held[i]),
            .code_o(code[i]),
            .oe_o(oe[i])
        );
    end

    // Outputs come straight from the slice and state flip-flops
    assign analog_out_ch0_o = code[0];
    assign analog_out_ch0_oe_o = oe[0];
    assign analog_out_ch1_o = code[1];
    assign analog_out_ch1_oe_o = oe[1];
    assign rdata_o = st_reg.rdata;
    assign sample_queue_ready_o = st_reg.q_ready;

    // Register writes, sample staging and read data
    always_comb begin
        st_next = st_reg;
        st_next.rdata = '0;
        st_next.q_ready = q_in_ready;
        if (wr_mode) begin
            // Reserved bits are never stored, so they read back zero
            st_next.mode = bus_i.wdata & `MODE_WMASK;
        end
        if (wr_sample0) begin
            st_next.sample0 = bus_i.wdata;
        end else if (q_pop) begin
            st_next.sample0 = q_data;
        end
        if (wr_sample1) begin
            st_next.sample1 = bus_i.wdata;
        end
        // Overflow clears by writing one; a lost push in the same cycle
        // sets it again
        if (wr_status && bus_i.wdata[`ST_OVF_BIT]) begin
            st_next.ovf = 1'b0;
        end
        if (wr_queue && !q_in_ready) begin
            st_next.ovf = 1'b1;
        end
        // Read data stands for the one cycle after the strobe only
        if (bus_i.rd) begin
            case (bus_i.addr)
                `OFS_SAMPLE0: st_next.rdata = st_reg.sample0;
                `OFS_SAMPLE1: st_next.rdata = st_reg.sample1;
                `OFS_MODE: st_next.rdata = st_reg.mode;
                `OFS_OUT0: st_next.rdata = code[0];
                `OFS_OUT1: st_next.rdata = code[1];
                `OFS_STATUS: begin
                    st_next.rdata[`ST_EMPTY_BIT] = !q_out_valid;
                    st_next.rdata[`ST_FULL_BIT] = !q_in_ready;
                    st_next.rdata[`ST_OVF_BIT] = st_reg.ovf;
                end
                default: st_next.rdata = '0;
            endcase
        end
    end

    // Reset leaves both channels off, normal mode, samples zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg.mode <= `MODE_RST;
            st_reg.sample0 <= `SAMPLE_RST;
            st_reg.sample1 <= `SAMPLE_RST;
            st_reg.rdata <= '0;
            st_reg.ovf <= 1'b0;
            st_reg.q_ready <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Normal mode: a sample write appears on the next edge
    a_normal_write: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (wr_sample0 && !st_reg.mode[`MODE_RT0_BIT])
        |=> (analog_out_ch0_o == $past(bus_i.wdata)))
    else $error("ch0 normal write not shown");

    // Real-time mode: no change without a timer 1 event
    a_rt_hold: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_reg.mode[`MODE_RT0_BIT] && !timer1_match_event_i)
        |=> $stable(analog_out_ch0_o))
    else $error("ch0 moved without trigger");

    // Timer 1 event shows the sample staged before it
    a_rt_trig_ch0: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_reg.mode[`MODE_RT0_BIT] && timer1_match_event_i)
        |=> (analog_out_ch0_o == $past(st_reg.sample0)))
    else $error("ch0 trigger value wrong");

    // Channel 1 follows timer 2, not timer 1
    a_rt_trig_ch1: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_reg.mode[`MODE_RT1_BIT] && timer2_match_event_i)
        |=> (analog_out_ch1_o == $past(st_reg.sample1)))
    else $error("ch1 trigger value wrong");

    // Stopped channel 0 releases its pin one edge later
    a_hiz_stopped: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !st_reg.mode[`MODE_EN0_BIT] |=> !analog_out_ch0_oe_o)
    else $error("ch0 driven while stopped");

    // Mode bit 4 written lands in the channel 0 real-time select
    a_mode_rt_sel: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        wr_mode |=> (st_reg.mode[`MODE_RT0_BIT] == $past(bus_i.wdata[4]))
            && (st_reg.mode[3:2] == 2'h0) && (st_reg.mode[7:6] == 2'h0))
    else $error("mode write mis-stored");

    // Writing 01h enables channel 0 in normal mode within two edges
    a_enable_normal: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (wr_mode && bus_i.wdata == 8'h01)
        |=> (ctrl[0].en && !ctrl[0].rt) ##1 analog_out_ch0_oe_o)
    else $error("ch0 not enabled by 01h");

    // Real-time from reset: zero stays until the first trigger
    a_zero_until_trig: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_reg.mode[`MODE_RT0_BIT] && analog_out_ch0_o == 8'h00 &&
            !timer1_match_event_i) |=> (analog_out_ch0_o == 8'h00))
    else $error("ch0 left zero without trigger");

    // First edge after reset shows a cleared mode and idle outputs
    a_reset_state: assert property (
        @(posedge clk_i)
        $rose(rst_b_i) |-> (st_reg.mode == `MODE_RST) &&
            !analog_out_ch0_oe_o && !analog_out_ch1_oe_o)
    else $error("reset state wrong");

    // Sample register read returns its value one cycle later
    a_sample_read: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (bus_i.rd && bus_i.addr == `OFS_SAMPLE1)
        |=> (rdata_o == $past(st_reg.sample1)))
    else $error("sample 1 readback wrong");

    // Channel 1 stays put between timer 2 events, whatever timer 1 does
    a_rt_hold_ch1: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (st_reg.mode[`MODE_RT1_BIT] && !timer2_match_event_i)
        |=> $stable(analog_out_ch1_o))
    else $error("ch1 moved without trigger");

    // Stopped channel 1 releases its pin one edge later
    a_hiz_stopped_ch1: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !st_reg.mode[`MODE_EN1_BIT] |=> !analog_out_ch1_oe_o)
    else $error("ch1 driven while stopped");

    // Enabled channel 0 drives its pin one edge later
    a_enabled_drive: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        st_reg.mode[`MODE_EN0_BIT] |=> analog_out_ch0_oe_o)
    else $error("ch0 not driven while enabled");

    // Normal mode: a channel 1 write appears on the next edge
    a_normal_write_ch1: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (wr_sample1 && !st_reg.mode[`MODE_RT1_BIT])
        |=> (analog_out_ch1_o == $past(bus_i.wdata)))
    else $error("ch1 normal write not shown");

    // Real-time write is staged in the sample register, not lost
    a_rt_stage_write: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (wr_sample0 && st_reg.mode[`MODE_RT0_BIT])
        |=> (st_reg.sample0 == $past(bus_i.wdata)))
    else $error("ch0 staged sample lost");

    // Normal mode: a queued sample popped to channel 0 shows next edge
    a_normal_pop: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (q_pop && !st_reg.mode[`MODE_RT0_BIT])
        |=> (analog_out_ch0_o == $past(q_data)))
    else $error("ch0 queue pop not shown");

    // Output code readback returns the level code one cycle later
    a_out1_readback: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (bus_i.rd && bus_i.addr == `OFS_OUT1)
        |=> (rdata_o == $past(analog_out_ch1_o)))
    else $error("ch1 output readback wrong");

    // Sample register 0 read returns its value one cycle later
    a_sample0_read: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (bus_i.rd && bus_i.addr == `OFS_SAMPLE0)
        |=> (rdata_o == $past(st_reg.sample0)))
    else $error("sample 0 readback wrong");

    // Both codes are zero at the first edge after reset, so 0 V shows
    a_reset_codes: assert property (
        @(posedge clk_i)
        $rose(rst_b_i) |-> (analog_out_ch0_o == 8'h00) &&
            (analog_out_ch1_o == 8'h00))
    else $error("codes not zero after reset");

endmodule : dac_trigger_control

// >>> hw/dac_trigger_regs.svh
// Register offsets, field positions and reset values of the two-channel
// converter control block. Assumes an 8-bit register port with a 3-bit
// word address; every register is one byte wide.
//
// How it works
// - Two channels, each from own 8-bit sample
// - Normal mode: sample write updates output now
// - Real-time mode: output changes only on trigger
// - Timer 1 triggers channel 0, timer 2 channel 1
// - Loaded channel 0 value shows at next trigger
// - Stopped channel drives high-impedance output
// - Output equals reference times code over 256
// - Mode bit 4 selects channel 0 real-time
// - Mode bit 0 enables channel 0 conversion
// - Real-time after reset holds 0 V until trigger
`ifndef DAC_TRIGGER_REGS_SVH
`define DAC_TRIGGER_REGS_SVH

`define ADDR_W 3
`define DATA_W 8
`define QUEUE_DEPTH 8

`define OFS_SAMPLE0 3'h0
`define OFS_SAMPLE1 3'h1
`define OFS_MODE 3'h2
`define OFS_OUT0 3'h3
`define OFS_OUT1 3'h4
`define OFS_QUEUE 3'h5
`define OFS_STATUS 3'h6

`define MODE_EN0_BIT 0
`define MODE_EN1_BIT 1
`define MODE_RT0_BIT 4
`define MODE_RT1_BIT 5
`define MODE_WMASK 8'h33
`define MODE_RST 8'h00
`define SAMPLE_RST 8'h00

`define ST_EMPTY_BIT 0
`define ST_FULL_BIT 1
`define ST_OVF_BIT 2

`endif

// >>> hw/dac_trigger_pkg.sv
// Types shared by the converter control block and its channel slices.
// Assumes the register header is on the include path.
`include "dac_trigger_regs.svh"

package dac_trigger_pkg;

    typedef logic [`DATA_W-1:0] code_t;
    typedef logic [`ADDR_W-1:0] addr_t;

    // One register-port request; strobes are one cycle, never both
    typedef struct packed {
        logic wr;
        logic rd;
        addr_t addr;
        code_t wdata;
    } bus_req_s;

    // Per-channel control bits taken from the mode register
    typedef struct packed {
        logic en;
        logic rt;
    } chan_ctrl_s;

    // Whole state of the top module
    typedef struct packed {
        code_t mode;
        code_t sample0;
        code_t sample1;
        code_t rdata;
        logic ovf;
        logic q_ready;
    } top_state_s;

    // Whole state of one channel slice
    typedef struct packed {
        code_t code;
        logic oe;
    } chan_state_s;

endpackage : dac_trigger_pkg

// >>> hw/dac_sample_fifo.sv
// Small synchronous FIFO for queued channel 0 samples.
// Assumes one clock; push is ignored while full, pop while empty.
`timescale 1ns/1ps

module dac_sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } fifo_state_s;

    fifo_state_s st_reg;
    fifo_state_s st_next;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty without a counter
    assign full = (st_reg.wptr[AW] != st_reg.rptr[AW]) &&
        (st_reg.wptr[AW-1:0] == st_reg.rptr[AW-1:0]);
    assign empty = (st_reg.wptr == st_reg.rptr);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = st_reg.mem[st_reg.rptr[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        st_next = st_reg;
        if (in_valid_i && !full) begin
            st_next.mem[st_reg.wptr[AW-1:0]] = in_data_i;
            st_next.wptr = st_reg.wptr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            st_next.rptr = st_reg.rptr + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : dac_sample_fifo

// >>> hw/dac_channel.sv
// One converter channel: output code latch and output enable.
// Assumes control, trigger and load come from logic on the same clock.
`timescale 1ns/1ps

module dac_channel (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire dac_trigger_pkg::chan_ctrl_s ctrl_i,
    input wire logic trigger_i,
    input wire logic load_i,
    input wire dac_trigger_pkg::code_t load_value_i,
    input wire dac_trigger_pkg::code_t held_value_i,
    output dac_trigger_pkg::code_t code_o,
    output logic oe_o
);
    import dac_trigger_pkg::*;

    chan_state_s st_reg;
    chan_state_s st_next;

    // Code feeds the resistor string: level is reference * code / 256
    assign code_o = st_reg.code;
    assign oe_o = st_reg.oe;

    // Real-time mode ignores loads so a write between triggers is staged
    always_comb begin
        st_next = st_reg;
        st_next.oe = ctrl_i.en;
        if (ctrl_i.rt) begin
            if (trigger_i) begin
                st_next.code = held_value_i;
            end
        end else if (load_i) begin
            st_next.code = load_value_i;
        end
    end

    // Code resets to zero, so early real-time use shows 0 V
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : dac_channel

// >>> tb/timer_match_model.sv
// Model of the two interval timers that trigger the converter channels.
// Assumes the bench asks for a shot and a latency in clock cycles.
`timescale 1ns/1ps

module timer_match_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] shot_i,
    input wire logic [3:0] lat_i,
    input wire logic timer1_run_i,
    output logic timer1_match_event_o,
    output logic timer2_match_event_o
);
    // Sine case: compare 175 minus one; one clock stands for one tick of
    // the 262 kHz count clock, so the 668 us interval is scaled down
    localparam logic [7:0] timer1_compare_value = 8'hae;
    logic [3:0] cnt_reg [2];
    logic [7:0] tick_reg;

    // Interval count for the sine case, restarted at each match
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_reg <= 8'h00;
        end else if (!timer1_run_i || tick_reg == timer1_compare_value) begin
            tick_reg <= 8'h00;
        end else begin
            tick_reg <= tick_reg + 8'h01;
        end
    end

    // Count the latency down; a long latency models a slow interval
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        for (int i = 0; i < 2; i++) begin
            if (!rst_b_i) begin
                cnt_reg[i] <= 4'h0;
            end else if (shot_i[i]) begin
                cnt_reg[i] <= lat_i;
            end else if (cnt_reg[i] != 4'h0) begin
                cnt_reg[i] <= cnt_reg[i] - 4'h1;
            end
        end
    end

    // Match pulses last one cycle, so a level never retriggers
    assign timer1_match_event_o = (cnt_reg[0] == 4'h1) ||
        (timer1_run_i && tick_reg == timer1_compare_value);
    assign timer2_match_event_o = (cnt_reg[1] == 4'h1);
endmodule : timer_match_model

// >>> tb/dac_trigger_control_tb.sv
// Self-checking bench for the two-channel converter control block.
// Assumes the register header and package are compiled first.
`timescale 1ns/1ps
`include "dac_trigger_regs.svh"

module dac_trigger_control_tb;
    import dac_trigger_pkg::*;
    logic clk_i, rst_b_i, oe0, oe1, q_rdy, t1, t2, rd_seen;
    bus_req_s bus_i;
    code_t rdata_o, out0, out1, a, b;
    logic [1:0] shot;
    logic [3:0] lat;
    int errors, n_tests, seed;
    code_t exp_q[$];
    code_t v[9];
    logic timer1_run;
    logic [4:0] idx;
    // One full sine cycle from mid-scale; index wraps after the last
    localparam logic [4:0] table_last_index = 5'h1d;
    code_t sine_tbl[30] = '{8'h9b, 8'hb4, 8'hcb, 8'hdf, 8'hef, 8'hfa,
        8'hff, 8'hff, 8'hfa, 8'hef, 8'hdf, 8'hcb, 8'hb4, 8'h9b, 8'h80,
        8'h65, 8'h4c, 8'h35, 8'h21, 8'h11, 8'h06, 8'h01, 8'h01, 8'h06,
        8'h11, 8'h21, 8'h35, 8'h4c, 8'h65, 8'h80};

    dac_trigger_control dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .timer1_match_event_i(t1),
        .timer2_match_event_i(t2), .analog_out_ch0_o(out0),
        .analog_out_ch0_oe_o(oe0), .analog_out_ch1_o(out1),
        .analog_out_ch1_oe_o(oe1), .sample_queue_ready_o(q_rdy));

    timer_match_model tm (.clk_i(clk_i), .rst_b_i(rst_b_i), .shot_i(shot),
        .lat_i(lat), .timer1_run_i(timer1_run),
        .timer1_match_event_o(t1), .timer2_match_event_o(t2));

    // Free-running 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input code_t seen, input code_t want);
        n_tests++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("errors %0d of n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // One-cycle register write, strobe dropped at the taking edge
    task automatic wr(input addr_t ad, input code_t d);
        @(posedge clk_i);
        bus_i <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : wr

    // Read: the expected value waits in the queue for the watcher
    task automatic rd(input addr_t ad, input code_t want);
        exp_q.push_back(want);
        @(posedge clk_i);
        bus_i <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : rd

    // Ask a timer for a match after a random latency, then settle
    task automatic fire(input int ch);
        @(posedge clk_i);
        lat <= 4'h1 + 4'($random(seed) & 3);
        shot <= 2'(1 << ch);
        @(posedge clk_i);
        shot <= 2'b00;
        repeat (lat) @(posedge clk_i);
        #1;
    endtask : fire

    task automatic see(input code_t w0, input code_t w1);
        check(out0, w0);
        check(out1, w1);
    endtask : see

    // Wait for a timer 1 match at a rising edge; none within 400 edges counts an error and ends the run
    task automatic wait_t1;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (t1 !== 1'b1 && n < 400);
        if (t1 !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
        #1;
    endtask : wait_t1

    task automatic do_reset;
        rst_b_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
    endtask : do_reset

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_seen) begin
            check(rdata_o, exp_q.size() ? exp_q.pop_front() : 8'hee);
        end
        rd_seen <= bus_i.rd;
    end

    // A hang is cut short and counted
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        tally_and_finish();
    end

    initial begin
        rst_b_i = 1'b0;
        bus_i = '0;
        shot = 2'b00;
        lat = 4'h1;
        timer1_run = 1'b0;
        rd_seen = 1'b0;
        errors = 0;
        n_tests = 0;
        seed = 32'h3a24;
        do_reset();
        // Reset state, reserved bits and unmapped places
        rd(`OFS_MODE, `MODE_RST);
        #1;
        check(code_t'({oe1, oe0, q_rdy}), 8'h01);
        wr(`OFS_MODE, 8'hff);
        rd(`OFS_MODE, 8'h33);
        rd(3'h7, 8'h00);
        rd(`OFS_QUEUE, 8'h00);
        // Normal mode: each write is its own trigger
        wr(`OFS_MODE, 8'h03);
        #1;
        check(code_t'({oe1, oe0}), 8'h03);
        for (int i = 0; i < 4; i++) begin
            a = code_t'($random(seed));
            b = code_t'($random(seed));
            wr(`OFS_SAMPLE0, a);
            #1;
            check(out0, a);
            wr(`OFS_SAMPLE1, b);
            #1;
            see(a, b);
            rd(`OFS_OUT0, a);
            rd(`OFS_OUT1, b);
        end
        // Real-time mode: writes wait for the matching timer
        wr(`OFS_MODE, 8'h33);
        wr(`OFS_SAMPLE0, 8'h5a);
        wr(`OFS_SAMPLE1, 8'ha5);
        #1;
        see(a, b);
        fire(1);
        see(a, 8'ha5);
        fire(0);
        see(8'h5a, 8'ha5);
        for (int i = 0; i < 6; i++) begin
            a = code_t'($random(seed));
            wr(`OFS_SAMPLE0, a);
            fire(0);
            check(out0, a);
        end
        // Stopping channel 1 releases its output
        wr(`OFS_MODE, 8'h11);
        // Enable reaches the pin one edge after the mode write
        @(posedge clk_i);
        #1;
        check(code_t'({oe1, oe0}), 8'h01);
        // Queue: fill past full, clear overflow, drain on triggers
        for (int i = 0; i < 9; i++) begin
            v[i] = code_t'($random(seed));
            wr(`OFS_QUEUE, v[i]);
        end
        #1;
        check(code_t'(q_rdy), 8'h00);
        rd(`OFS_STATUS, 8'h06);
        wr(`OFS_STATUS, 8'h04);
        rd(`OFS_STATUS, 8'h02);
        for (int i = 0; i < 9; i++) begin
            fire(0);
            check(out0, i == 0 ? a : v[i-1]);
        end
        rd(`OFS_STATUS, 8'h01);
        rd(`OFS_SAMPLE0, v[7]);
        // Let the last read data be taken before reset clears it
        @(posedge clk_i);
        // Real-time straight after reset holds zero until a trigger
        do_reset();
        #1;
        check(code_t'({oe1, oe0}), 8'h00);
        wr(`OFS_MODE, 8'h11);
        wr(`OFS_SAMPLE0, 8'hc3);
        #1;
        check(code_t'({oe1, oe0}), 8'h01);
        see(8'h00, 8'h00);
        fire(0);
        check(out0, 8'hc3);
        // Sine feeder: normal start, then real-time, then the timer
        wr(`OFS_MODE, 8'h01);
        wr(`OFS_SAMPLE0, sine_tbl[0]);
        #1;
        check(out0, sine_tbl[0]);
        wr(`OFS_MODE, 8'h11);
        timer1_run <= 1'b1;
        idx = 5'h00;
        for (int k = 0; k < 32; k++) begin
            wait_t1();
            check(out0, sine_tbl[idx]);
            idx = (idx >= table_last_index) ? 5'h00 : idx + 5'h01;
            wr(`OFS_SAMPLE0, sine_tbl[idx]);
        end
        timer1_run <= 1'b0;
        // Normal mode drains a queued sample straight to the output
        wr(`OFS_MODE, 8'h01);
        a = code_t'($random(seed));
        wr(`OFS_QUEUE, a);
        @(posedge clk_i);
        #1;
        check(out0, a);
        repeat (2) @(posedge clk_i);
        tally_and_finish();
    end
endmodule : dac_trigger_control_tb
